// ===== common/adc_touch_consts.svh
// Register offsets, field positions and reset values of the converter controller
`ifndef ADC_TOUCH_CONSTS_SVH
`define ADC_TOUCH_CONSTS_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define A_CMD 8'h00
`define A_MODE 8'h04
`define A_SEQ1 8'h08
`define A_CHEN 8'h10
`define A_CHDIS 8'h14
`define A_CHST 8'h18
`define A_LAST 8'h20
`define A_IEN 8'h24
`define A_IDIS 8'h28
`define A_IMASK 8'h2c
`define A_IFLAG 8'h30
`define A_OVR 8'h3c
`define A_EXT 8'h40
`define A_CWIN 8'h44
`define A_CDR0 8'h50
`define A_CDR11 8'h7c
`define A_ACR 8'h94
`define A_TCFG 8'hb0
`define A_TX 8'hb4
`define A_TY 8'hb8
`define A_TP 8'hbc
`define A_TRG 8'hc0
`define A_LOCK 8'he4
`define A_LSTAT 8'he8
// ----------------------------------------
// Fields
// ----------------------------------------
`define CMD_RST 0
`define CMD_START 1
`define CMD_CAL 2
`define MODE_RES 4
`define MODE_SLEEP 5
`define MODE_DIV_LSB 8
`define MODE_SUT_LSB 16
`define MODE_ORDER 31
`define EXT_TAG 24
`define TCFG_PEN 24
`define LOCK_EN 0
`define LSTAT_FLAG 0
`define LSTAT_SRC_LSB 8
`define IRQ_XRDY 20
`define IRQ_YRDY 21
`define IRQ_PRDY 22
`define IRQ_DRDY 24
`define IRQ_PEN 29
`define IRQ_NOPEN 30
`define IRQ_LIVE 31
`define CH_NUM 12
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_ACR 32'h00000100
`define SUT_LO_TABLE {7'h70, 7'h60, 7'h50, 7'h40, 7'h18, 7'h10, 7'h08, 7'h00}
`define SUT_HI_BASE 10'h200
`define SUT_HI_STEP 10'h040
`endif

// ===== common/adc_touch_pkg.sv
// Types shared by the converter controller modules
package adc_touch_pkg;
  typedef enum logic [1:0] {TK_X, TK_Y, TK_Z1, TK_Z2} ts_kind_t;

  typedef struct packed {
    logic [31:0] mode;
    logic [31:0] seq1;
    logic [31:0] ext;
    logic [31:0] cwin;
    logic [31:0] acr;
    logic [31:0] tcfg;
    logic [31:0] trg;
    logic lock_en;
    logic lflag;
    logic [7:0] lsrc;
    logic [11:0] chst;
    logic [15:0] last;
    logic [31:0] imask;
    logic [31:0] iflag;
    logic [11:0] ovr;
    logic [11:0][11:0] cdr;
    logic [31:0] tx;
    logic [31:0] ty;
    logic [31:0] tp;
    logic contact_live_state_q;
    logic [1:0] cal_cnt;
    logic start_p;
    logic cal_p;
    logic pdown;
    logic irq;
    logic [31:0] rdata;
  } regs_t;

  typedef struct packed {
    logic [7:0] divcnt;
    logic clk_lvl;
    logic [9:0] sut_cnt;
    logic ready;
  } clkgen_t;
endpackage : adc_touch_pkg

// ===== common/conv_clk_if.sv
// Link between register block and converter clock generator
`timescale 1ns/1ps
interface conv_clk_if;
  logic [7:0] divider;
  logic [3:0] sut;
  logic wake;
  logic soft_rst;
  logic clk_lvl;
  logic ready;
  modport ctrl (output divider, output sut, output wake, output soft_rst, input clk_lvl, input ready);
  modport gen (input divider, input sut, input wake, input soft_rst, output clk_lvl, output ready);
endinterface : conv_clk_if

// ===== rtl/conv_clk_gen.sv
// Converter clock divider and startup delay counter
`timescale 1ns/1ps
`include "adc_touch_consts.svh"
module conv_clk_gen (
  input wire logic clk_i,
  input wire logic reset_i,
  conv_clk_if.gen ck
);
  import adc_touch_pkg::*;

  clkgen_t s;
  clkgen_t n;
  logic rise;

  function automatic logic [9:0] sut_len(input logic [3:0] c);
    logic [55:0] lo;
    lo = `SUT_LO_TABLE;
    if (!c[3]) begin
      sut_len = {3'h0, lo[c[2:0] * 7 +: 7]};
    end else begin
      sut_len = `SUT_HI_BASE + 10'(c[2:0]) * `SUT_HI_STEP;
    end
  endfunction : sut_len

  always_comb begin
    n = s;
    rise = 1'b0;
    // ----------------------------------------
    // Half period of divider+1 clocks
    // ----------------------------------------
    if (s.divcnt == ck.divider) begin
      n.divcnt = 8'h00;
      n.clk_lvl = ~s.clk_lvl; // RULE_14
      rise = ~s.clk_lvl;
    end else begin
      n.divcnt = s.divcnt + 8'h01;
    end
    // ----------------------------------------
    // Startup delay in converter periods
    // ----------------------------------------
    if (ck.wake) begin
      n.sut_cnt = sut_len(ck.sut); // RULE_15
      n.ready = (sut_len(ck.sut) == 10'h000);
    end else if (!s.ready && rise) begin
      n.sut_cnt = s.sut_cnt - 10'h001;
      n.ready = (s.sut_cnt == 10'h001);
    end
    // ----------------------------------------
    // Software reset of divider and startup state
    // ----------------------------------------
    if (ck.soft_rst) begin
      n = '0; // RULE_08
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign ck.clk_lvl = s.clk_lvl;
  assign ck.ready = s.ready;
endmodule : conv_clk_gen

// ===== rtl/adc_touch_ctrl_regs.sv
// Register file and control of the converter controller with touch support
// Notes on behaviour
// RULE_01 - Contact sensing on, tagging on, no contact: touch results stored as zero.
// RULE_02 - With contact present, touch results are stored unchanged.
// RULE_03 - Tagging off: touch results stored plain, untagged; sensing off with tagging on stores them tagged.
// RULE_04 - Lock bit protects mode, order, enables, extended, window, analog, touch, trigger.
// RULE_05 - Write to a locked register sets violation flag and records its offset.
// RULE_06 - Reading the lock status register clears the violation flag.
// RULE_07 - Software must ignore unlisted offsets; they read zero.
// RULE_08 - Command bit 0 resets the whole controller like a hardware reset.
// RULE_09 - Command bit 1 starts a conversion.
// RULE_10 - Command bit 2 calibrates: next sequence if busy, else second sequence.
// RULE_11 - Touch results during calibration never update the latest result register; channel results still do.
// RULE_12 - Mode register takes writes only while the lock bit is clear.
// RULE_13 - Sleep bit powers core and reference down between conversions.
// RULE_14 - Converter clock is peripheral clock over two times divider plus one.
// RULE_15 - Startup code selects 0..112 or 512..960 converter periods.
// RULE_16 - Tagged touch values carry 0,1,2,3 for X, Y, first, second pressure.
// RULE_17 - Status register shows live contact state.
// RULE_18 - A blocked write leaves the register unchanged.
// RULE_19 - Command bits are pulses, not stored; command register reads zero.
`timescale 1ns/1ps
`include "adc_touch_consts.svh"
module adc_touch_ctrl_regs (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire logic ch_valid_i,
  input wire logic [3:0] ch_num_i,
  input wire logic [11:0] ch_data_i,
  input wire logic ts_valid_i,
  input wire adc_touch_pkg::ts_kind_t ts_kind_i,
  input wire logic [11:0] ts_data_i,
  input wire logic calib_active_i,
  input wire logic seq_start_i,
  input wire logic seq_busy_i,
  input wire logic contact_live_i,
  output logic conv_start_o,
  output logic calib_start_o,
  output logic power_down_o,
  output logic reduced_resolution_o,
  output logic custom_order_en_o,
  output logic contact_sense_en_o,
  output logic [11:0] chan_enabled_o,
  output logic conv_clock_o,
  output logic startup_done_o
);
  import adc_touch_pkg::*;

  localparam regs_t RST_S = '{acr: `RST_ACR, default: '0};

  regs_t s;
  regs_t n;
  logic [4:0] cidx;
  logic [15:0] ts_word;
  logic tag_en;
  logic sense_en;

  conv_clk_if ck ();

  // ----------------------------------------
  // Converter clock and startup
  // ----------------------------------------
  conv_clk_gen u_clk (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ck(ck.gen)
  );

  assign ck.divider = s.mode[`MODE_DIV_LSB +: 8];
  assign ck.sut = s.mode[`MODE_SUT_LSB +: 4];
  assign ck.wake = s.start_p;
  assign ck.soft_rst = wr_i && (addr_i == `A_CMD) && wdata_i[`CMD_RST]; // RULE_08

  assign cidx = addr_i[6:2] - 5'h14;
  assign tag_en = s.ext[`EXT_TAG];
  assign sense_en = s.tcfg[`TCFG_PEN];

  function automatic logic prot(input logic [7:0] a);
    case (a)
      `A_MODE, `A_SEQ1, `A_CHEN, `A_CHDIS, `A_EXT: prot = 1'b1;
      `A_CWIN, `A_ACR, `A_TCFG, `A_TRG: prot = 1'b1;
      default: prot = 1'b0;
    endcase
  endfunction : prot

  // ----------------------------------------
  // Touch word forwarded to latest result
  // ----------------------------------------
  always_comb begin
    if (sense_en && tag_en && !s.contact_live_state_q) begin
      ts_word = 16'h0000; // RULE_01
    end else if (tag_en) begin
      ts_word = {2'h0, ts_kind_i, ts_data_i}; // RULE_02 RULE_16
    end else begin
      ts_word = {4'h0, ts_data_i}; // RULE_03
    end
  end

  always_comb begin
    n = s;
    n.start_p = 1'b0;
    n.cal_p = 1'b0;
    n.rdata = 32'h00000000;

    // ----------------------------------------
    // Reads
    // ----------------------------------------
    if (rd_i) begin
      case (addr_i)
        `A_MODE: n.rdata = s.mode;
        `A_SEQ1: n.rdata = s.seq1;
        `A_CHST: n.rdata = {20'h00000, s.chst};
        `A_LAST: n.rdata = {16'h0000, s.last};
        `A_IMASK: n.rdata = s.imask;
        `A_IFLAG: begin
          n.rdata = s.iflag;
          n.rdata[`IRQ_LIVE] = s.contact_live_state_q; // RULE_17
        end
        `A_OVR: begin
          n.rdata = {20'h00000, s.ovr};
          n.ovr = 12'h000;
        end
        `A_EXT: n.rdata = s.ext;
        `A_CWIN: n.rdata = s.cwin;
        `A_ACR: n.rdata = s.acr;
        `A_TCFG: n.rdata = s.tcfg;
        `A_TX: n.rdata = s.tx;
        `A_TY: n.rdata = s.ty;
        `A_TP: n.rdata = s.tp;
        `A_TRG: n.rdata = s.trg;
        `A_LOCK: n.rdata = {31'h00000000, s.lock_en};
        `A_LSTAT: begin
          n.rdata[`LSTAT_FLAG] = s.lflag;
          n.rdata[`LSTAT_SRC_LSB +: 8] = s.lsrc;
          n.lflag = 1'b0; // RULE_06
        end
        default: begin
          if (addr_i >= `A_CDR0 && addr_i <= `A_CDR11 && addr_i[1:0] == 2'h0) begin
            n.rdata = {20'h00000, s.cdr[cidx[3:0]]};
          end else begin
            n.rdata = 32'h00000000; // RULE_07 RULE_19
          end
        end
      endcase
    end

    // ----------------------------------------
    // Writes
    // ----------------------------------------
    if (wr_i) begin
      if (s.lock_en && prot(addr_i)) begin
        n.lflag = 1'b1; // RULE_04 RULE_05 RULE_12 RULE_18
        n.lsrc = addr_i;
      end else begin
        case (addr_i)
          `A_CMD: begin
            n.start_p = wdata_i[`CMD_START]; // RULE_09 RULE_19
            if (wdata_i[`CMD_CAL]) begin
              n.cal_cnt = seq_busy_i ? 2'h1 : 2'h2; // RULE_10
            end
          end
          `A_MODE: n.mode = wdata_i;
          `A_SEQ1: n.seq1 = wdata_i;
          `A_CHEN: n.chst = s.chst | wdata_i[11:0];
          `A_CHDIS: n.chst = s.chst & ~wdata_i[11:0];
          `A_IEN: n.imask = s.imask | wdata_i;
          `A_IDIS: n.imask = s.imask & ~wdata_i;
          `A_IFLAG: n.iflag = s.iflag & ~wdata_i;
          `A_EXT: n.ext = wdata_i;
          `A_CWIN: n.cwin = wdata_i;
          `A_ACR: n.acr = wdata_i;
          `A_TCFG: n.tcfg = wdata_i;
          `A_TRG: n.trg = wdata_i;
          `A_LOCK: n.lock_en = wdata_i[`LOCK_EN];
          default: n.rdata = n.rdata;
        endcase
      end
    end

    // ----------------------------------------
    // Calibration scheduling
    // ----------------------------------------
    if (seq_start_i && s.cal_cnt != 2'h0 && !(wr_i && addr_i == `A_CMD && wdata_i[`CMD_CAL])) begin
      n.cal_cnt = s.cal_cnt - 2'h1; // RULE_10
      n.cal_p = (s.cal_cnt == 2'h1);
    end

    // ----------------------------------------
    // Contact events
    // ----------------------------------------
    n.contact_live_state_q = contact_live_i; // RULE_17
    if (contact_live_i && !s.contact_live_state_q) begin
      n.iflag[`IRQ_PEN] = 1'b1;
      n.iflag[`IRQ_NOPEN] = 1'b0;
    end
    if (!contact_live_i && s.contact_live_state_q) begin
      n.iflag[`IRQ_NOPEN] = 1'b1;
      n.iflag[`IRQ_PEN] = 1'b0;
    end

    // ----------------------------------------
    // Channel results
    // ----------------------------------------
    if (ch_valid_i && ch_num_i < 4'hc) begin
      if (s.iflag[ch_num_i]) begin
        n.ovr[ch_num_i] = 1'b1;
      end
      n.cdr[ch_num_i] = ch_data_i;
      n.iflag[ch_num_i] = 1'b1;
      n.iflag[`IRQ_DRDY] = 1'b1;
      n.last = {(tag_en ? ch_num_i : 4'h0), ch_data_i};
    end

    // ----------------------------------------
    // Touch results
    // ----------------------------------------
    if (ts_valid_i) begin
      case (ts_kind_i)
        TK_X: begin
          n.tx[15:0] = {4'h0, ts_data_i};
          n.iflag[`IRQ_XRDY] = 1'b1;
        end
        TK_Y: begin
          n.ty[15:0] = {4'h0, ts_data_i};
          n.iflag[`IRQ_YRDY] = 1'b1;
        end
        TK_Z1: n.tp[15:0] = {4'h0, ts_data_i};
        TK_Z2: begin
          n.tp[31:16] = {4'h0, ts_data_i};
          n.iflag[`IRQ_PRDY] = 1'b1;
        end
        default: n.tp = s.tp;
      endcase
      if (!calib_active_i) begin
        n.last = ts_word; // RULE_11
        n.iflag[`IRQ_DRDY] = 1'b1;
      end
    end

    // ----------------------------------------
    // Power and interrupt outputs
    // ----------------------------------------
    n.pdown = n.mode[`MODE_SLEEP] && !seq_busy_i; // RULE_13
    n.irq = |(n.iflag & n.imask);

    // ----------------------------------------
    // Software reset
    // ----------------------------------------
    if (wr_i && addr_i == `A_CMD && wdata_i[`CMD_RST]) begin
      n = RST_S; // RULE_08
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o = s.rdata;
  assign irq_o = s.irq;
  assign conv_start_o = s.start_p;
  assign calib_start_o = s.cal_p;
  assign power_down_o = s.pdown;
  assign reduced_resolution_o = s.mode[`MODE_RES];
  assign custom_order_en_o = s.mode[`MODE_ORDER];
  assign contact_sense_en_o = s.tcfg[`TCFG_PEN];
  assign chan_enabled_o = s.chst;
  assign conv_clock_o = ck.clk_lvl;
  assign startup_done_o = ck.ready;
endmodule : adc_touch_ctrl_regs

// ===== sim/adc_regs_sva.sv
// Checker on the ports of the register block
`timescale 1ns/1ps
module adc_regs_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic conv_start_o,
  input wire logic calib_start_o,
  input wire logic power_down_o,
  input wire logic seq_start_i,
  input wire logic seq_busy_i,
  input wire logic contact_sense_en_o,
  input wire logic [11:0] chan_enabled_o,
  input wire logic conv_clock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_cmd_rd;
    rd_i && addr_i == 8'h00 |=> rdata_o == 32'h0;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command read not zero");
  property p_start;
    wr_i && addr_i == 8'h00 && wdata_i[1] && !wdata_i[0] |=> conv_start_o;
  endproperty
  a_start: assert property (p_start) else $error("start pulse missing");
  property p_pulse;
    conv_start_o |-> $past(wr_i && addr_i == 8'h00 && wdata_i[1]);
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse without command");
  property p_srst;
    wr_i && addr_i == 8'h00 && wdata_i[0] |=> !power_down_o && !contact_sense_en_o && chan_enabled_o == 12'h0
      && !conv_clock_o;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset left state");
  property p_pd;
    seq_busy_i |=> !power_down_o;
  endproperty
  a_pd: assert property (p_pd) else $error("powered down while busy");
  property p_wpsr;
    rd_i && addr_i == 8'he8 ##1 !wr_i ##1 rd_i && addr_i == 8'he8 |=> !rdata_o[0];
  endproperty
  a_wpsr: assert property (p_wpsr) else $error("violation flag not cleared");
  property p_cal;
    calib_start_o |-> $past(seq_start_i);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration outside sequence start");
  property p_lock;
    !wr_i ##2 wr_i && addr_i == 8'he4 && wdata_i[0] ##2 wr_i && addr_i == 8'hb0
      |=> $stable(contact_sense_en_o) [*2];
  endproperty
  a_lock: assert property (p_lock) else $error("locked register changed");
endmodule : adc_regs_sva
bind adc_touch_ctrl_regs adc_regs_sva adc_regs_sva_i (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .conv_start_o, .calib_start_o, .power_down_o, .seq_start_i, .seq_busy_i,
  .contact_sense_en_o, .chan_enabled_o, .conv_clock_o);

// ===== sim/touch_front_model.sv
// Converter front end model feeding touch results and sequence starts
`timescale 1ns/1ps
module touch_front_model (
  input wire logic clk_i,
  output logic ts_valid_o,
  output adc_touch_pkg::ts_kind_t ts_kind_o,
  output logic [11:0] ts_data_o,
  output logic calib_o,
  output logic seq_start_o
);
  import adc_touch_pkg::*;
  initial begin
    ts_valid_o = 1'b0;
    ts_kind_o = TK_X;
    ts_data_o = 12'h000;
    calib_o = 1'b0;
    seq_start_o = 1'b0;
  end
  task automatic touch(input ts_kind_t k, input logic [11:0] d, input logic cal);
    @(posedge clk_i);
    ts_valid_o <= 1'b1;
    ts_kind_o <= k;
    ts_data_o <= d;
    calib_o <= cal;
    @(posedge clk_i);
    ts_valid_o <= 1'b0;
    ts_data_o <= ~d;
    calib_o <= 1'b0;
  endtask : touch
  task automatic seq_pulse();
    @(posedge clk_i);
    seq_start_o <= 1'b1;
    @(posedge clk_i);
    seq_start_o <= 1'b0;
  endtask : seq_pulse
endmodule : touch_front_model

// ===== sim/testbench.sv
// Self-checking bench of the register block
`timescale 1ns/1ps
module testbench;
  import adc_touch_pkg::*;
  logic clk_i, reset_i, wr_i, rd_i, live_i, busy_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic irq_o, conv_start_o, calib_start_o, pd, ckv, tsv, cal, seqs;
  logic reduced_resolution, order, sdone;
  ts_kind_t tsk;
  logic [11:0] tsd;
  int err_count = 0;
  int n_compared = 0;
  logic [7:0] prot [9] = '{8'hb0, 8'h04, 8'h08, 8'h10, 8'h14, 8'h40, 8'h44, 8'h94, 8'hc0};
  adc_touch_ctrl_regs adc_touch_ctrl_regs_i (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .irq_o, .ch_valid_i(1'b0), .ch_num_i(4'h0), .ch_data_i(12'h000), .ts_valid_i(tsv), .ts_kind_i(tsk),
    .ts_data_i(tsd), .calib_active_i(cal), .seq_start_i(seqs), .seq_busy_i(busy_i),
    .contact_live_i(live_i), .conv_start_o, .calib_start_o, .power_down_o(pd), .reduced_resolution_o(reduced_resolution),
    .custom_order_en_o(order), .contact_sense_en_o(), .chan_enabled_o(), .conv_clock_o(ckv),
    .startup_done_o(sdone));
  touch_front_model touch_front_model_i (.clk_i, .ts_valid_o(tsv), .ts_kind_o(tsk), .ts_data_o(tsd),
    .calib_o(cal), .seq_start_o(seqs));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask : rd
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    rd(a, t);
    check(nm, t, exp);
  endtask : rchk
  task automatic seq_chk(input logic exp);
    touch_front_model_i.seq_pulse();
    @(negedge clk_i);
    check("calib_start", calib_start_o, exp);
  endtask : seq_chk
  task automatic irq_chk(input logic exp);
    repeat (2) @(negedge clk_i);
    check("irq", irq_o, exp);
  endtask : irq_chk
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  function automatic logic [31:0] exp_last(input logic sen, tag, live, input logic [1:0] k,
                                           input logic [11:0] d);
    if (sen && tag && !live) return 32'h0;
    return {16'h0, tag ? {2'b00, k} : 4'h0, d};
  endfunction : exp_last
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    final_report();
  end
  initial begin
    logic [31:0] v, r, e;
    logic [11:0] d;
    logic p;
    int n;
    {reset_i, wr_i, rd_i, live_i, busy_i, addr_i, wdata_i} = {1'b1, 44'h0};
    void'($urandom(32'h124645ee));
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    rchk("mode", 8'h04, 32'h0);
    rchk("acr", 8'h94, 32'h100);
    rchk("cmd", 8'h00, 32'h0);
    rchk("unmapped", 8'h0c, 32'h0);
    v = $urandom;
    wr(8'h08, v);
    rchk("seq1", 8'h08, v);
    wr(8'h00, 32'h2);
    @(negedge clk_i);
    check("conv_start", conv_start_o, 1);
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_i);
      live_i <= i[2];
      wr(8'h40, {7'h0, i[3], 24'h0});
      wr(8'hb0, {7'h0, i[4], 24'h0});
      d = 12'($urandom);
      touch_front_model_i.touch(ts_kind_t'(i[1:0]), d, 1'b0);
      e = exp_last(i[4], i[3], i[2], i[1:0], d);
      rchk("latest", 8'h20, e);
    end
    touch_front_model_i.touch(TK_X, ~d, 1'b1);
    rchk("latest", 8'h20, e);
    wr(8'h00, 32'h4);
    seq_chk(1'b0);
    seq_chk(1'b1);
    @(posedge clk_i);
    busy_i <= 1'b1;
    wr(8'h00, 32'h4);
    seq_chk(1'b1);
    @(posedge clk_i);
    busy_i <= 1'b0;
    wr(8'h24, 32'h00200000);
    touch_front_model_i.touch(TK_Y, 12'h5a5, 1'b0);
    irq_chk(1'b1);
    wr(8'h28, 32'h00200000);
    irq_chk(1'b0);
    wr(8'h24, 32'h00200000);
    irq_chk(1'b1);
    wr(8'h30, 32'h00200000);
    irq_chk(1'b0);
    rd(8'h30, r);
    check("live", r[31], 1);
    wr(8'he4, 32'h1);
    foreach (prot[j]) begin
      wr(prot[j], $urandom);
      rchk("lock_status", 8'he8, {16'h0, prot[j], 8'h01});
    end
    rd(8'he8, r);
    check("lock_flag", r[0], 0);
    rchk("seq1", 8'h08, v);
    rchk("mode", 8'h04, 32'h0);
    wr(8'he4, 32'h0);
    wr(8'h04, 32'h80000330);
    rchk("mode", 8'h04, 32'h80000330);
    check("reduced_resolution", reduced_resolution, 1);
    check("custom_order", order, 1);
    check("power_down", pd, 1);
    p = ckv;
    n = 0;
    repeat (16) begin
      @(negedge clk_i);
      if (ckv !== p) n++;
      p = ckv;
    end
    check("conv_clock_toggles", n, 4);
    wr(8'h00, 32'h1);
    rchk("mode", 8'h04, 32'h0);
    rchk("acr", 8'h94, 32'h100);
    wr(8'h04, 32'h00010000);
    wr(8'h00, 32'h2);
    @(negedge clk_i);
    check("startup_done", sdone, 0);
    repeat (20) @(negedge clk_i);
    check("startup_done", sdone, 1);
    final_report();
  end
endmodule : testbench
